// ===== rtl/pmcg_clock_gate.sv
// Glitch-free gate for one peripheral clock
module pmcg_clock_gate (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    output logic gated_clk
);
    logic en_low_reg;

    // Enable changes only while the clock is low, so no pulse is ever cut short
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_low_reg <= 1'b0;
        end else begin
            en_low_reg <= enable;
        end
    end

    assign gated_clk = clk & en_low_reg;
endmodule

// ===== rtl/pmcg_defines.svh
// Register offsets, field positions, reset values and timing counts of the clock gating block
//==============================================================================
// Function
// - Status bit 0 reads 1 while the processor clock runs, 0 when gated.
// - Read-only status bit shows whether the USB host clock is enabled.
// - Read-only status bit shows whether the USB device clock is enabled.
// - Four status bits show which programmable clock outputs are enabled.
// - Writing 1 to set bit n (2..31) enables peripheral clock n; 0 no effect.
// - Gating bits of unimplemented peripherals change nothing.
// - Writing 1 to clear bit n (2..31) disables peripheral clock n; 0 no effect.
// - Peripheral status returns 1 per enabled clock, 0 per disabled one.
// - Enable bit starts the oscillator, clearing stops it; bypass kept 0 meanwhile.
// - Stable flag rises only after the programmed start-up time has elapsed.
// - Bypass sets the stable flag at once; clock comes from outside.
// - Stable flag clears when enable and bypass are both written 0.
// - Start-up time is the count field times 8 slow clock cycles.
// - Measure field holds main clock cycles seen within 16 slow clock periods.
// - Measure-ready reads 0 while invalid or oscillator off, 1 once valid.
// - Divider 0 stops output, 1 passes through, 2..255 divides by value.
// - After each PLL configuration write, wait the lock count, then set lock.
// - Multiplier 0 turns the PLL off; 1..2047 gives input times value plus one.
// - Writing 1 to a programmable clock set bit enables that output.
// - Each enabled peripheral clock is the master clock, gated per peripheral.
//==============================================================================
`ifndef PMCG_DEFINES_SVH
`define PMCG_DEFINES_SVH

`define PMCG_OFF_SYS_SET 12'h000
`define PMCG_OFF_SYS_CLR 12'h004
`define PMCG_OFF_SYS_STATE 12'h008
`define PMCG_OFF_PER_SET 12'h010
`define PMCG_OFF_PER_CLR 12'h014
`define PMCG_OFF_PER_STATE 12'h018
`define PMCG_OFF_OSC_CTRL 12'h020
`define PMCG_OFF_FREQ 12'h024
`define PMCG_OFF_PLL_CFG 12'h028
`define PMCG_OFF_STATUS 12'h068

`define PMCG_SYS_STATE_RESET 32'h0000_0003
`define PMCG_SYS_WR_MASK 32'h0000_0fc1
`define PMCG_PLL_CFG_RESET 32'h0000_3f00
`define PMCG_PLL_CFG_MASK 32'h27ff_ffff
`define PMCG_OSC_CTRL_MASK 32'h0000_ff03
`define PMCG_PER_MASK 32'hffff_fffc

`define PMCG_BIT_PROC 0
`define PMCG_BIT_UHOST 6
`define PMCG_BIT_UDEV 7
`define PMCG_BIT_PROG_LSB 8
`define PMCG_BIT_OSC_EN 0
`define PMCG_BIT_OSC_BYP 1
`define PMCG_OSC_CNT_LSB 8
`define PMCG_FREQ_VALID_BIT 16
`define PMCG_PLL_DIV_LSB 0
`define PMCG_PLL_CNT_LSB 8
`define PMCG_PLL_RANGE_LSB 14
`define PMCG_PLL_MUL_LSB 16
`define PMCG_STAT_OSC_STABLE 0
`define PMCG_STAT_PLL_LOCK 1

`define PMCG_OSC_MULT 3
`define PMCG_MEASURE_SLOW_CYCLES 5'h10

`endif

// ===== rtl/pmcg_pkg.sv
// Types shared by the clock gating block
package pmcg_pkg;
    typedef enum logic [1:0] {
        OSC_OFF = 2'b00,
        OSC_START = 2'b01,
        OSC_STABLE = 2'b10,
        OSC_BYPASS = 2'b11
    } pmcg_osc_state_t;

    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b00,
        MEAS_ALIGN = 2'b01,
        MEAS_COUNT = 2'b10,
        MEAS_DONE = 2'b11
    } pmcg_meas_state_t;

    typedef struct packed {
        logic enable;
        logic bypass;
    } pmcg_osc_ctrl_t;

    typedef struct packed {
        logic off;
        logic [7:0] divider;
        logic [10:0] multiplier;
        logic [1:0] range;
    } pmcg_pll_cfg_t;
endpackage

// ===== rtl/pmcg_top.sv
// Clock gating, main oscillator control and first PLL configuration with APB access
`include "pmcg_defines.svh"
module pmcg_top #(
    parameter logic [31:0] PER_IMPL_MASK = `PMCG_PER_MASK
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_clock_pin,
    input wire logic main_clock_pin,
    output pmcg_pkg::pmcg_osc_ctrl_t osc_ctrl,
    output pmcg_pkg::pmcg_pll_cfg_t first_pll_cfg,
    output logic processor_clock_on,
    output logic usb_host_clock_on,
    output logic usb_device_clock_on,
    output logic [3:0] prog_clock_output_on,
    output logic [31:0] periph_clock
);
    import pmcg_pkg::*;

    //==========================================================================
    // APB decode
    logic [31:0] sys_state_reg;
    logic [31:0] per_state_reg;
    logic [31:0] osc_ctrl_reg;
    logic [31:0] pll_cfg_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] rd_mux;
    logic hit;

    wire setup = psel & ~penable;
    wire wr_go = psel & penable & pready_reg & pwrite;
    wire sel_sys_set = (paddr == `PMCG_OFF_SYS_SET);
    wire sel_sys_clr = (paddr == `PMCG_OFF_SYS_CLR);
    wire sel_sys_state = (paddr == `PMCG_OFF_SYS_STATE);
    wire sel_per_set = (paddr == `PMCG_OFF_PER_SET);
    wire sel_per_clr = (paddr == `PMCG_OFF_PER_CLR);
    wire sel_per_state = (paddr == `PMCG_OFF_PER_STATE);
    wire sel_osc = (paddr == `PMCG_OFF_OSC_CTRL);
    wire sel_freq = (paddr == `PMCG_OFF_FREQ);
    wire sel_pll = (paddr == `PMCG_OFF_PLL_CFG);
    wire sel_status = (paddr == `PMCG_OFF_STATUS);
    wire wr_sys_set = wr_go & sel_sys_set;
    wire wr_sys_clr = wr_go & sel_sys_clr;
    wire wr_per_set = wr_go & sel_per_set;
    wire wr_per_clr = wr_go & sel_per_clr;
    wire wr_osc = wr_go & sel_osc;
    wire wr_pll = wr_go & sel_pll;

    //==========================================================================
    // Pin synchronisers: a level is accepted once stages two and three agree
    logic [2:0] slow_sync_reg;
    logic [2:0] main_sync_reg;
    logic slow_level_reg;
    logic main_level_reg;
    logic slow_level_next;
    logic main_level_next;

    assign slow_level_next = (slow_sync_reg[1] == slow_sync_reg[2]) ?
                             slow_sync_reg[2] : slow_level_reg;
    assign main_level_next = (main_sync_reg[1] == main_sync_reg[2]) ?
                             main_sync_reg[2] : main_level_reg;
    wire slow_tick = slow_level_next & ~slow_level_reg;
    wire main_tick = main_level_next & ~main_level_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_sync_reg <= 3'h0;
            main_sync_reg <= 3'h0;
            slow_level_reg <= 1'b0;
            main_level_reg <= 1'b0;
        end else begin
            slow_sync_reg <= {slow_sync_reg[1:0], slow_clock_pin};
            main_sync_reg <= {main_sync_reg[1:0], main_clock_pin};
            slow_level_reg <= slow_level_next;
            main_level_reg <= main_level_next;
        end
    end

    //==========================================================================
    // System and peripheral clock gating state
    logic [31:0] sys_state_next;
    logic [31:0] per_state_next;

    // Writes touch only implemented bits, so other bits keep their reset value
    assign sys_state_next = wr_sys_set ? (sys_state_reg | (pwdata & `PMCG_SYS_WR_MASK)) :
                            wr_sys_clr ? (sys_state_reg & ~(pwdata & `PMCG_SYS_WR_MASK)) :
                            sys_state_reg;
    assign per_state_next = wr_per_set ? (per_state_reg | (pwdata & PER_IMPL_MASK)) :
                            wr_per_clr ? (per_state_reg & ~(pwdata & PER_IMPL_MASK)) :
                            per_state_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_state_reg <= `PMCG_SYS_STATE_RESET;
            per_state_reg <= 32'h0;
        end else begin
            sys_state_reg <= sys_state_next;
            per_state_reg <= per_state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            processor_clock_on <= 1'b1;
            usb_host_clock_on <= 1'b0;
            usb_device_clock_on <= 1'b0;
            prog_clock_output_on <= 4'h0;
        end else begin
            processor_clock_on <= sys_state_next[`PMCG_BIT_PROC];
            usb_host_clock_on <= sys_state_next[`PMCG_BIT_UHOST];
            usb_device_clock_on <= sys_state_next[`PMCG_BIT_UDEV];
            prog_clock_output_on <= sys_state_next[`PMCG_BIT_PROG_LSB +: 4];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_gate
            if (PER_IMPL_MASK[gi]) begin : g_impl
                pmcg_clock_gate u_gate (
                    .clk(pclk),
                    .rst_n(presetn),
                    .enable(per_state_reg[gi]),
                    .gated_clk(periph_clock[gi])
                );
            end else begin : g_none
                assign periph_clock[gi] = 1'b0;
            end
        end
    endgenerate

    //==========================================================================
    // Main oscillator control and start-up timing
    pmcg_osc_state_t osc_state_reg;
    pmcg_osc_state_t osc_state_next;
    logic [10:0] osc_cnt_reg;
    logic [10:0] osc_cnt_next;
    logic [31:0] osc_ctrl_next;

    assign osc_ctrl_next = wr_osc ? (pwdata & `PMCG_OSC_CTRL_MASK) : osc_ctrl_reg;
    wire osc_en_next = osc_ctrl_next[`PMCG_BIT_OSC_EN];
    wire osc_byp_next = osc_ctrl_next[`PMCG_BIT_OSC_BYP];
    wire [10:0] osc_target = {osc_ctrl_reg[`PMCG_OSC_CNT_LSB +: 8], 3'b000};

    always_comb begin
        osc_state_next = osc_state_reg;
        osc_cnt_next = osc_cnt_reg;
        case (osc_state_reg)
            OSC_OFF: begin
                osc_cnt_next = 11'h0;
                if (osc_byp_next) begin
                    osc_state_next = OSC_BYPASS;
                end else if (osc_en_next) begin
                    osc_state_next = OSC_START;
                end
            end
            OSC_START: begin
                if (osc_cnt_reg >= osc_target) begin
                    osc_state_next = OSC_STABLE;
                end else if (slow_tick) begin
                    osc_cnt_next = osc_cnt_reg + 11'h1;
                end
            end
            OSC_STABLE, OSC_BYPASS: begin
                osc_state_next = osc_state_reg;
            end
            default: begin
                osc_state_next = OSC_OFF;
            end
        endcase
        // Bypass and stop both override whatever the sequence was doing
        if (osc_byp_next) begin
            osc_state_next = OSC_BYPASS;
        end else if (!osc_en_next) begin
            osc_state_next = OSC_OFF;
        end else if (osc_state_reg == OSC_BYPASS) begin
            osc_state_next = OSC_START;
            osc_cnt_next = 11'h0;
        end
    end

    wire osc_stable = (osc_state_reg == OSC_STABLE) || (osc_state_reg == OSC_BYPASS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_ctrl_reg <= 32'h0;
            osc_state_reg <= OSC_OFF;
            osc_cnt_reg <= 11'h0;
            osc_ctrl <= '0;
        end else begin
            osc_ctrl_reg <= osc_ctrl_next;
            osc_state_reg <= osc_state_next;
            osc_cnt_reg <= osc_cnt_next;
            osc_ctrl.enable <= osc_en_next;
            osc_ctrl.bypass <= osc_byp_next;
        end
    end

    //==========================================================================
    // Main clock frequency measurement over a fixed slow clock window
    pmcg_meas_state_t meas_state_reg;
    pmcg_meas_state_t meas_state_next;
    logic [4:0] win_cnt_reg;
    logic [4:0] win_cnt_next;
    logic [15:0] main_cnt_reg;
    logic [15:0] main_cnt_next;
    logic [15:0] freq_reg;
    logic [15:0] freq_next;

    always_comb begin
        meas_state_next = meas_state_reg;
        win_cnt_next = win_cnt_reg;
        main_cnt_next = main_cnt_reg;
        freq_next = freq_reg;
        case (meas_state_reg)
            MEAS_IDLE: begin
                if (osc_stable) begin
                    meas_state_next = MEAS_ALIGN;
                end
            end
            MEAS_ALIGN: begin
                // Start on a slow edge so the window is whole periods
                win_cnt_next = 5'h0;
                main_cnt_next = 16'h0;
                if (slow_tick) begin
                    meas_state_next = MEAS_COUNT;
                end
            end
            MEAS_COUNT: begin
                if (main_tick && main_cnt_reg != 16'hffff) begin
                    main_cnt_next = main_cnt_reg + 16'h1;
                end
                if (slow_tick) begin
                    win_cnt_next = win_cnt_reg + 5'h1;
                end
                if (win_cnt_next == `PMCG_MEASURE_SLOW_CYCLES) begin
                    freq_next = main_cnt_next;
                    meas_state_next = MEAS_DONE;
                end
            end
            MEAS_DONE: begin
                meas_state_next = MEAS_DONE;
            end
            default: begin
                meas_state_next = MEAS_IDLE;
            end
        endcase
        if (!osc_stable) begin
            meas_state_next = MEAS_IDLE;
        end
    end

    wire freq_valid = (meas_state_reg == MEAS_DONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_state_reg <= MEAS_IDLE;
            win_cnt_reg <= 5'h0;
            main_cnt_reg <= 16'h0;
            freq_reg <= 16'h0;
        end else begin
            meas_state_reg <= meas_state_next;
            win_cnt_reg <= win_cnt_next;
            main_cnt_reg <= main_cnt_next;
            freq_reg <= freq_next;
        end
    end

    //==========================================================================
    // First PLL configuration and lock timer
    logic [31:0] pll_cfg_next;
    logic [5:0] lock_cnt_reg;
    logic [5:0] lock_cnt_next;
    logic locked_reg;
    logic locked_next;

    // Bit 29 is stored as written; software is expected to keep it at one
    assign pll_cfg_next = wr_pll ? (pwdata & `PMCG_PLL_CFG_MASK) : pll_cfg_reg;
    wire [7:0] pll_div = pll_cfg_next[`PMCG_PLL_DIV_LSB +: 8];
    wire [10:0] pll_mul = pll_cfg_next[`PMCG_PLL_MUL_LSB +: 11];
    wire [5:0] lock_target = pll_cfg_reg[`PMCG_PLL_CNT_LSB +: 6];

    always_comb begin
        lock_cnt_next = lock_cnt_reg;
        locked_next = locked_reg;
        if (wr_pll) begin
            lock_cnt_next = 6'h0;
            locked_next = 1'b0;
        end else if (!locked_reg) begin
            if (lock_cnt_reg >= lock_target) begin
                locked_next = 1'b1;
            end else if (slow_tick) begin
                lock_cnt_next = lock_cnt_reg + 6'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_cfg_reg <= `PMCG_PLL_CFG_RESET;
            lock_cnt_reg <= 6'h0;
            locked_reg <= 1'b0;
            first_pll_cfg <= '0;
        end else begin
            pll_cfg_reg <= pll_cfg_next;
            lock_cnt_reg <= lock_cnt_next;
            locked_reg <= locked_next;
            first_pll_cfg.off <= (pll_div == 8'h0) || (pll_mul == 11'h0);
            first_pll_cfg.divider <= pll_div;
            first_pll_cfg.multiplier <= pll_mul;
            first_pll_cfg.range <= pll_cfg_next[`PMCG_PLL_RANGE_LSB +: 2];
        end
    end

    //==========================================================================
    // Read mux and APB answer; one wait-free access with registered data
    assign hit = sel_sys_set | sel_sys_clr | sel_sys_state | sel_per_set | sel_per_clr |
                 sel_per_state | sel_osc | sel_freq | sel_pll | sel_status;
    assign rd_mux = sel_sys_state ? sys_state_reg :
                    sel_per_state ? per_state_reg :
                    sel_osc ? osc_ctrl_reg :
                    sel_freq ? {15'h0, freq_valid, freq_reg} :
                    sel_pll ? pll_cfg_reg :
                    sel_status ? {30'h0, locked_reg, osc_stable} :
                    32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~hit;
            prdata_reg <= (setup & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
endmodule

// ===== tb/pmcg_checker.sv
// Port-level assertions for the clock gating block
`include "pmcg_defines.svh"
module pmcg_checker #(
    parameter logic [31:0] PER_IMPL_MASK = `PMCG_PER_MASK
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic slow_clock_pin,
    input wire logic main_clock_pin,
    input wire pmcg_pkg::pmcg_osc_ctrl_t osc_ctrl,
    input wire pmcg_pkg::pmcg_pll_cfg_t first_pll_cfg,
    input wire logic processor_clock_on,
    input wire logic usb_host_clock_on,
    input wire logic usb_device_clock_on,
    input wire logic [3:0] prog_clock_output_on,
    input wire logic [31:0] periph_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmcg_pkg::*;
    //==========================================================================
    // Helper logic
    wire acc_w = psel && penable && pready && pwrite;
    logic [31:0] wd_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wd_reg <= 32'h0000_0000;
        else if (acc_w) wd_reg <= pwdata;
    end
    // Expected gate enables, kept from the set and clear writes seen on the bus
    logic [31:0] gate_shadow_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gate_shadow_reg <= 32'h0000_0000;
        else if (acc_w && paddr == `PMCG_OFF_PER_SET)
            gate_shadow_reg <= gate_shadow_reg | (pwdata & PER_IMPL_MASK);
        else if (acc_w && paddr == `PMCG_OFF_PER_CLR)
            gate_shadow_reg <= gate_shadow_reg & ~pwdata;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    //==========================================================================
    // Bus answer
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    unmapped_err_a: assert property (pready && paddr == 12'h00c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    //==========================================================================
    // Outputs follow register writes
    proc_off_a: assert property (acc_w && paddr == `PMCG_OFF_SYS_CLR && pwdata[0]
        |-> ##2 !processor_clock_on) else $error("processor clock not gated");
    pll_pins_a: assert property (acc_w && paddr == `PMCG_OFF_PLL_CFG |-> ##2
        first_pll_cfg.divider == wd_reg[7:0] && first_pll_cfg.multiplier == wd_reg[26:16]
        && first_pll_cfg.range == wd_reg[15:14]) else $error("pll pins differ from write");
    pll_off_a: assert property ($past(presetn) |-> first_pll_cfg.off ==
        (first_pll_cfg.divider == 8'h00 || first_pll_cfg.multiplier == 11'h000))
        else $error("pll off flag wrong");
    osc_pins_a: assert property (acc_w && paddr == `PMCG_OFF_OSC_CTRL |-> ##2
        osc_ctrl.enable == wd_reg[0] && osc_ctrl.bypass == wd_reg[1])
        else $error("oscillator pins differ from write");
    // High phase sampled, so a gate that should be shut shows as a stray pulse
    gate_mask_a: assert property (@(negedge pclk) disable iff (!presetn)
        (periph_clock & ~PER_IMPL_MASK) == 32'h0000_0000 &&
        periph_clock == $past(gate_shadow_reg)) else $error("gate output differs from enables");
endmodule

// ===== tb/tb.sv
// Register-level testbench for the clock gating block
`include "pmcg_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmcg_pkg::*;
    localparam logic [31:0] IMPL = 32'hfff0_fffc;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [11:0] SST = `PMCG_OFF_SYS_STATE;
    localparam logic [11:0] PST = `PMCG_OFF_PER_STATE;
    localparam logic [11:0] OSC = `PMCG_OFF_OSC_CTRL;
    localparam logic [11:0] FRQ = `PMCG_OFF_FREQ;
    localparam logic [11:0] PLL = `PMCG_OFF_PLL_CFG;
    localparam logic [11:0] STA = `PMCG_OFF_STATUS;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic slow_clock_pin = 1'b0;
    logic main_clock_pin = 1'b0;
    logic [31:0] prdata;
    logic [31:0] periph_clock;
    logic pready;
    logic pslverr;
    logic processor_clock_on;
    logic usb_host_clock_on;
    logic usb_device_clock_on;
    logic [3:0] prog_clock_output_on;
    pmcg_osc_ctrl_t osc_ctrl;
    pmcg_pll_cfg_t first_pll_cfg;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [31:0] q;
    logic e;

    always #5 pclk = ~pclk;
    // Slow clock of 480 ns and main clock of 40 ns: 192 main cycles per window
    always #240 slow_clock_pin = ~slow_clock_pin;
    always #20 main_clock_pin = ~main_clock_pin;

    pmcg_top #(.PER_IMPL_MASK(IMPL)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_clock_pin(slow_clock_pin), .main_clock_pin(main_clock_pin),
        .osc_ctrl(osc_ctrl), .first_pll_cfg(first_pll_cfg),
        .processor_clock_on(processor_clock_on), .usb_host_clock_on(usb_host_clock_on),
        .usb_device_clock_on(usb_device_clock_on),
        .prog_clock_output_on(prog_clock_output_on), .periph_clock(periph_clock)
    );

    //==========================================================================
    // Tasks
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Entered just after a rising edge; leaves one edge after the release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, ex, q & m);
    endtask

    task automatic wait_slow(input int n);
        repeat (n) @(posedge slow_clock_pin);
        @(posedge pclk);
    endtask

    //==========================================================================
    // Tests
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc("sys_rst", SST, ALL, 32'h0000_0003);
        rc("per_rst", PST, ALL, 32'h0000_0000);
        rc("osc_rst", OSC, ALL, 32'h0000_0000);
        rc("frq_rst", FRQ, ALL, 32'h0000_0000);
        rc("pll_rst", PLL, ALL, 32'h0000_3f00);
        chk("proc_on", 32'h1, {31'h0, processor_clock_on});
        wr(`PMCG_OFF_SYS_SET, 32'h0000_0fc0);
        rc("sys_set", SST, ALL, 32'h0000_0fc3);
        chk("sys_pins", 32'h7f, {25'h0, usb_host_clock_on, usb_device_clock_on,
            prog_clock_output_on, processor_clock_on});
        wr(`PMCG_OFF_SYS_CLR, 32'h0000_0141);
        rc("sys_clr", SST, ALL, 32'h0000_0e82);
        chk("proc_off", 32'h0, {31'h0, processor_clock_on});
        chk("sys_pins2", 32'h3c, {25'h0, usb_host_clock_on, usb_device_clock_on,
            prog_clock_output_on, processor_clock_on});
        wr(`PMCG_OFF_SYS_SET, 32'h0000_0001);
        rc("sys_proc", SST, ALL, 32'h0000_0e83);
        wr(`PMCG_OFF_PER_SET, ALL);
        rc("per_set", PST, ALL, IMPL);
        wr(`PMCG_OFF_PER_CLR, 32'h0000_0110);
        wr(`PMCG_OFF_PER_SET, 32'h0000_0000);
        wr(`PMCG_OFF_PER_CLR, 32'h0000_0000);
        wr(PST, 32'h0000_0000);
        rc("per_clr", PST, ALL, IMPL & ~32'h0000_0110);
        rc("per_wo", `PMCG_OFF_PER_SET, ALL, 32'h0000_0000);
        #2;
        chk("gate_hi", IMPL & ~32'h0000_0110, periph_clock);
        @(negedge pclk);
        #2;
        chk("gate_lo", 32'h0000_0000, periph_clock);
        @(posedge pclk);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_rd", 32'h0, q);
        wr(PLL, 32'h2005_8403);
        rc("lock_early", STA, 32'h2, 32'h0);
        chk("pll_pins", {10'h0, 1'b0, 8'h03, 11'h005, 2'h2}, first_pll_cfg);
        wait_slow(2);
        rc("lock_mid", STA, 32'h2, 32'h0);
        wait_slow(4);
        rc("lock_done", STA, 32'h2, 32'h2);
        rc("pll_rd", PLL, ALL, 32'h2005_8403);
        wr(PLL, 32'h2005_8400);
        rc("lock_clr", STA, 32'h2, 32'h0);
        chk("pll_div0", 32'h1, {31'h0, first_pll_cfg.off});
        wr(PLL, 32'h2000_8401);
        rc("pll_rd2", PLL, ALL, 32'h2000_8401);
        chk("pll_mul0", 32'h1, {31'h0, first_pll_cfg.off});
        wr(OSC, 32'h0000_0201);
        wait_slow(12);
        rc("osc_early", STA, 32'h1, 32'h0);
        chk("osc_pins", 32'h2, {30'h0, osc_ctrl});
        rc("mrdy_early", FRQ, 32'h0001_0000, 32'h0);
        wait_slow(6);
        rc("osc_stable", STA, 32'h1, 32'h1);
        wait_slow(19);
        apb(1'b0, FRQ, 32'h0000_0000);
        chk("mrdy", 32'h1, {31'h0, q[16]});
        chk("mfreq", 32'h1, {31'h0, q[15:0] >= 16'h00be && q[15:0] <= 16'h00c2});
        wr(OSC, 32'h0000_0000);
        rc("osc_off", STA, 32'h1, 32'h0);
        rc("mrdy_off", FRQ, 32'h0001_0000, 32'h0);
        wr(OSC, 32'h0000_0002);
        repeat (3) @(posedge pclk);
        rc("osc_byp", STA, 32'h1, 32'h1);
        chk("byp_pins", 32'h1, {30'h0, osc_ctrl});
        rc("osc_rd", OSC, ALL, 32'h0000_0002);
        wr(OSC, 32'h0000_0000);
        rc("byp_off", STA, 32'h1, 32'h0);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc("per_rst2", PST, ALL, 32'h0000_0000);
        rc("sys_rst2", SST, ALL, 32'h0000_0003);
        close_out();
    end

    // Tests need about 22 us; a hang is cut off well beyond that
    initial begin
        #300000;
        n_mismatch++;
        close_out();
    end
endmodule

bind pmcg_top pmcg_checker #(.PER_IMPL_MASK(PER_IMPL_MASK)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_clock_pin(slow_clock_pin), .main_clock_pin(main_clock_pin),
    .osc_ctrl(osc_ctrl), .first_pll_cfg(first_pll_cfg),
    .processor_clock_on(processor_clock_on), .usb_host_clock_on(usb_host_clock_on),
    .usb_device_clock_on(usb_device_clock_on),
    .prog_clock_output_on(prog_clock_output_on), .periph_clock(periph_clock)
);
